// [rtl/pcs_div_if.sv]
// carrier between the loop core and one post-scale counter
`timescale 1ns/10ps
interface pcs_div_if;
    logic tick;
    logic sync;
    logic [8:0] period;
    logic [7:0] high;
    logic [7:0] phase;
    logic clk_out;

    modport ctrl (output tick, output sync, output period, output high, output phase,
                  input clk_out);
    modport div (input tick, input sync, input period, input high, input phase,
                 output clk_out);
endinterface

// [rtl/pcs_map.svh]
// register offsets, field positions, reset values and the behaviour summary of the pll control
//
// Contract
// - output frequency is reference times m over n times its post-scale count
// - phase shifts in eighths of the oscillator period, steps of 45 degrees
// - each of three post-scale counters has its own programmable high time
// - three counter outputs each feed the global clock network
// - third output drives the external pin, the global network, or both
// - user logic may swap between two reference clocks in user mode
// - lock asserts only when output is stable and in phase with reference
// - gated lock stays low until the programmed reference transition count elapses
// - gated or ungated lock is selectable for the lock output
// - zero-delay mode aligns the external pin with the clock input
// - normal mode compensates global network delay to the registers
// - no-compensation mode applies no delay compensation
// - power enable switches the loop on when high, off when low
// - asynchronous clear resets and resynchronises the loop inputs
// - detector gate input low blocks phase detector corrections
// - reference select comes from configuration or dynamically from logic
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

//------------------------------------------------------------
// register offsets (byte addresses)
//------------------------------------------------------------
`define PCS_OFF_CFG 8'h00
`define PCS_OFF_MULT 8'h04
`define PCS_OFF_GATE 8'h08
`define PCS_OFF_OUT0 8'h0C
`define PCS_OFF_OUT1 8'h10
`define PCS_OFF_OUT2 8'h14
`define PCS_OFF_STAT 8'h18
`define PCS_OFF_COMP 8'h1C

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define PCS_CFG_FB_LSB 0
`define PCS_CFG_SEL_STATIC 2
`define PCS_CFG_SEL_DYN 3
`define PCS_CFG_LOCK_GATED 4
`define PCS_CFG_EXT_EN 5
`define PCS_CFG_GCLK2_EN 6
`define PCS_MULT_M_LSB 0
`define PCS_MULT_N_LSB 8
`define PCS_OUT_C_LSB 0
`define PCS_OUT_HIGH_LSB 8
`define PCS_OUT_PHASE_LSB 16
`define PCS_COMP_NORM_LSB 0
`define PCS_COMP_ZDB_LSB 8
`define PCS_STAT_PERIOD_LSB 14

//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define PCS_CFG_RST 7'h60
`define PCS_M_RST 5'h00
`define PCS_N_RST 2'h0
`define PCS_GATE_RST 16'h0010
`define PCS_OUT_C_RST 5'h00
`define PCS_OUT_HIGH_RST 8'h04
`define PCS_OUT_PHASE_RST 8'h00
`define PCS_COMP_NORM_RST 8'h02
`define PCS_COMP_ZDB_RST 8'h01

`endif

// [rtl/pcs_pkg.sv]
// types and shared arithmetic of the pll control
package pcs_pkg;

    typedef enum logic [1:0] {
        PCS_FB_NORMAL,
        PCS_FB_ZDB,
        PCS_FB_NONE
    } pcs_fb_mode_e;

    typedef struct packed {
        logic [7:0] phase;
        logic [7:0] high;
        logic [4:0] c_m1;
    } pcs_out_cfg_s;

    // distance from b forward to a on a ring of m positions
    function automatic logic [8:0] pcs_wrap_sub(input logic [8:0] a, input logic [8:0] b,
                                                input logic [8:0] m);
        logic [9:0] s;
        s = (a >= b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, m} - {1'b0, b});
        return s[8:0];
    endfunction

endpackage

// [rtl/pcs_post_div.sv]
// post-scale counter with programmable phase and high time, counted in oscillator eighths
`timescale 1ns/10ps
module pcs_post_div (
    input wire logic pclk,
    input wire logic presetn,
    pcs_div_if.div dv
);
    import pcs_pkg::*;

    logic [8:0] cnt;
    logic [8:0] pos;

    //------------------------------------------------------------
    // ring position shifted by the phase setting
    //------------------------------------------------------------
    always_comb begin
        pos = pcs_wrap_sub(cnt, {1'b0, dv.phase}, dv.period);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 9'h000;
        end else if (dv.sync) begin
            cnt <= 9'h000;
        end else if (dv.tick) begin
            // wrap at c times eight eighths of the oscillator period
            cnt <= (cnt >= dv.period - 9'h001) ? 9'h000 : cnt + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dv.clk_out <= 1'b0;
        end else begin
            dv.clk_out <= (pos < {1'b0, dv.high});
        end
    end

endmodule // pcs_post_div

// [rtl/pcs_top.sv]
// pll control core: reference selection, oscillator model, lock logic and apb registers
`timescale 1ns/10ps
`include "pcs_map.svh"
module pcs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clk0,
    input wire logic ref_clk1,
    input wire logic pll_enable,
    input wire logic pll_areset,
    input wire logic pfd_enable,
    input wire logic reference_switch_select,
    output logic post_scale_out0,
    output logic post_scale_out1,
    output logic external_capable_output,
    output logic ext_clk_pin,
    output logic lock_out
);
    import pcs_pkg::*;

    //------------------------------------------------------------
    // configuration state
    //------------------------------------------------------------
    logic [1:0] fb_mode_raw;
    logic sel_static;
    logic sel_dyn;
    logic lock_gated_sel;
    logic ext_en;
    logic gclk2_en;
    logic [4:0] m_m1;
    logic [1:0] n_m1;
    logic [15:0] gate_cnt;
    pcs_out_cfg_s out_cfg [3];
    logic [7:0] comp_norm;
    logic [7:0] comp_zdb;

    //------------------------------------------------------------
    // loop state
    //------------------------------------------------------------
    logic ref_prev;
    logic sel_prev;
    logic [1:0] n_cnt;
    logic [17:0] per_cnt;
    logic [17:0] div_period;
    logic [1:0] meas_n;
    logic [17:0] acc;
    logic [8:0] fb_cnt;
    logic nco_on;
    logic locked_ungated;
    logic locked_gated;
    logic [15:0] gate_run;
    logic sync_q;

    logic active_ref;
    logic ref_now;
    logic rise;
    logic trans;
    logic run;
    logic restart;
    logic timeout;
    logic div_edge;
    logic [8:0] step;
    logic [8:0] fb_mod;
    logic [18:0] sum;
    logic [18:0] acc_sub;
    logic tick;
    logic [7:0] comp_val;
    logic [8:0] target;
    logic [8:0] ph_err;
    logic phase_ok;
    logic stable;
    logic align;
    logic [2:0] d_clk;

    //------------------------------------------------------------
    // shared arithmetic
    //------------------------------------------------------------
    // a count setting held as value minus one, turned into oscillator eighths
    function automatic logic [8:0] eighths(input logic [4:0] v_m1);
        return {({1'b0, v_m1} + 6'h01), 3'b000};
    endfunction

    //------------------------------------------------------------
    // reference selection and edge detection
    //------------------------------------------------------------
    always_comb begin
        active_ref = sel_dyn ? reference_switch_select : sel_static;
        ref_now = active_ref ? ref_clk1 : ref_clk0;
        rise = ref_now & ~ref_prev;
        trans = ref_now ^ ref_prev;
        run = pll_enable & ~pll_areset;
        // a clear or a swap of reference restarts measurement and alignment
        restart = ~run | (active_ref != sel_prev);
        timeout = &per_cnt;
        div_edge = rise & (n_cnt == n_m1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev <= 1'b0;
            sel_prev <= 1'b0;
        end else begin
            ref_prev <= ref_now;
            sel_prev <= active_ref;
        end
    end

    // input divider n and period of n reference cycles in pclk cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_cnt <= 2'h0;
            per_cnt <= 18'h00000;
            div_period <= 18'h00000;
            meas_n <= 2'h0;
        end else if (restart) begin
            n_cnt <= 2'h0;
            per_cnt <= 18'h00000;
            meas_n <= 2'h0;
        end else begin
            if (rise) begin
                n_cnt <= div_edge ? 2'h0 : n_cnt + 2'h1;
            end
            if (div_edge) begin
                per_cnt <= 18'h00001;
                if (meas_n != 2'h0) begin
                    div_period <= per_cnt;
                end
                if (meas_n != 2'h3) begin
                    meas_n <= meas_n + 2'h1;
                end
            end else if (timeout) begin
                meas_n <= 2'h0;
            end else begin
                per_cnt <= per_cnt + 18'h00001;
            end
        end
    end

    //------------------------------------------------------------
    // oscillator model: 8*m eighths per n reference periods
    //------------------------------------------------------------
    always_comb begin
        step = eighths(m_m1);
        fb_mod = step;
        sum = {1'b0, acc} + {10'h000, step};
        acc_sub = sum - {1'b0, div_period};
        tick = nco_on & (sum >= {1'b0, div_period});
        unique case (pcs_fb_mode_e'(fb_mode_raw))
            PCS_FB_NORMAL: comp_val = comp_norm;
            PCS_FB_ZDB: comp_val = comp_zdb;
            PCS_FB_NONE: comp_val = 8'h00;
            default: comp_val = 8'h00;
        endcase
        target = ({1'b0, comp_val} >= fb_mod) ? 9'h000 : {1'b0, comp_val};
        ph_err = pcs_wrap_sub(fb_cnt, target, fb_mod);
        // one eighth either way is accumulator jitter, not phase error
        phase_ok = (ph_err <= 9'h001) | (ph_err >= fb_mod - 9'h001);
        stable = (per_cnt <= div_period + 18'h00001) & (per_cnt + 18'h00001 >= div_period);
        align = div_edge & ((meas_n == 2'h1) |
                            (nco_on & ~phase_ok & pfd_enable));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_on <= 1'b0;
        end else begin
            nco_on <= ~restart & ~timeout & (nco_on | (div_edge & (meas_n == 2'h1)));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 18'h00000;
            fb_cnt <= 9'h000;
        end else if (restart) begin
            acc <= 18'h00000;
            fb_cnt <= 9'h000;
        end else if (align) begin
            acc <= 18'h00000;
            fb_cnt <= target;
        end else if (tick) begin
            acc <= (acc_sub >= {1'b0, div_period}) ? 18'h00000 : acc_sub[17:0];
            fb_cnt <= (fb_cnt >= fb_mod - 9'h001) ? 9'h000 : fb_cnt + 9'h001;
        end else if (nco_on) begin
            // between ticks the phase accumulator keeps gathering steps
            acc <= sum[17:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= align | restart;
        end
    end

    //------------------------------------------------------------
    // lock detection and gating counter
    //------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_ungated <= 1'b0;
        end else if (restart | timeout) begin
            locked_ungated <= 1'b0;
        end else if (div_edge & nco_on) begin
            locked_ungated <= stable & phase_ok & (meas_n == 2'h3);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_run <= 16'h0000;
            locked_gated <= 1'b0;
        end else if (restart | ~locked_ungated) begin
            gate_run <= 16'h0000;
            locked_gated <= 1'b0;
        end else begin
            if (trans & (gate_run < gate_cnt)) begin
                gate_run <= gate_run + 16'h0001;
            end
            locked_gated <= (gate_run >= gate_cnt);
        end
    end

    //------------------------------------------------------------
    // post-scale counters
    //------------------------------------------------------------
    pcs_div_if dvi [3] ();

    for (genvar g = 0; g < 3; g++) begin : g_div
        assign dvi[g].tick = tick;
        assign dvi[g].sync = sync_q;
        assign dvi[g].period = eighths(out_cfg[g].c_m1);
        assign dvi[g].high = out_cfg[g].high;
        assign dvi[g].phase = out_cfg[g].phase;
        assign d_clk[g] = dvi[g].clk_out;
        pcs_post_div u_div (
            .pclk(pclk),
            .presetn(presetn),
            .dv(dvi[g])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_scale_out0 <= 1'b0;
            post_scale_out1 <= 1'b0;
            external_capable_output <= 1'b0;
            ext_clk_pin <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            post_scale_out0 <= nco_on & d_clk[0];
            post_scale_out1 <= nco_on & d_clk[1];
            external_capable_output <= nco_on & gclk2_en & d_clk[2];
            ext_clk_pin <= nco_on & ext_en & d_clk[2];
            lock_out <= lock_gated_sel ? locked_gated : locked_ungated;
        end
    end

    //------------------------------------------------------------
    // apb slave: no wait state, registered answer
    //------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_go;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            `PCS_OFF_CFG: rd_word = {25'h0000000, gclk2_en, ext_en, lock_gated_sel, sel_dyn,
                                     sel_static, fb_mode_raw};
            `PCS_OFF_MULT: rd_word = {22'h000000, n_m1, 3'h0, m_m1};
            `PCS_OFF_GATE: rd_word = {16'h0000, gate_cnt};
            `PCS_OFF_OUT0: rd_word = {8'h00, out_cfg[0].phase, out_cfg[0].high, 3'h0,
                                      out_cfg[0].c_m1};
            `PCS_OFF_OUT1: rd_word = {8'h00, out_cfg[1].phase, out_cfg[1].high, 3'h0,
                                      out_cfg[1].c_m1};
            `PCS_OFF_OUT2: rd_word = {8'h00, out_cfg[2].phase, out_cfg[2].high, 3'h0,
                                      out_cfg[2].c_m1};
            `PCS_OFF_STAT: rd_word = {div_period, 9'h000, pfd_enable, nco_on, active_ref,
                                      locked_gated, locked_ungated};
            `PCS_OFF_COMP: rd_word = {16'h0000, comp_zdb, comp_norm};
            default: rd_hit = 1'b0;
        endcase
        wr_go = psel & penable & pready & pwrite & rd_hit & (paddr != `PCS_OFF_STAT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0000_0000;
            pslverr <= psel & ~penable & ~rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {gclk2_en, ext_en, lock_gated_sel, sel_dyn, sel_static, fb_mode_raw} <= `PCS_CFG_RST;
            m_m1 <= `PCS_M_RST;
            n_m1 <= `PCS_N_RST;
            gate_cnt <= `PCS_GATE_RST;
            comp_norm <= `PCS_COMP_NORM_RST;
            comp_zdb <= `PCS_COMP_ZDB_RST;
            for (int i = 0; i < 3; i++) begin
                out_cfg[i] <= {`PCS_OUT_PHASE_RST, `PCS_OUT_HIGH_RST, `PCS_OUT_C_RST};
            end
        end else if (wr_go) begin
            unique case (paddr)
                `PCS_OFF_CFG: {gclk2_en, ext_en, lock_gated_sel, sel_dyn, sel_static,
                               fb_mode_raw} <= pwdata[6:0];
                `PCS_OFF_MULT: begin
                    m_m1 <= pwdata[`PCS_MULT_M_LSB +: 5];
                    n_m1 <= pwdata[`PCS_MULT_N_LSB +: 2];
                end
                `PCS_OFF_GATE: gate_cnt <= pwdata[15:0];
                `PCS_OFF_OUT0: out_cfg[0] <= {pwdata[23:8], pwdata[4:0]};
                `PCS_OFF_OUT1: out_cfg[1] <= {pwdata[23:8], pwdata[4:0]};
                `PCS_OFF_OUT2: out_cfg[2] <= {pwdata[23:8], pwdata[4:0]};
                `PCS_OFF_COMP: begin
                    comp_norm <= pwdata[`PCS_COMP_NORM_LSB +: 8];
                    comp_zdb <= pwdata[`PCS_COMP_ZDB_LSB +: 8];
                end
                default: begin
                end
            endcase
        end
    end

endmodule // pcs_top

// [sim/pcs_ref_src.sv]
// reference clock sources standing in front of the pll control
`timescale 1ns/10ps
module pcs_ref_src #(
    parameter int HALF0 = 16,
    parameter int HALF1 = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic ref_clk0,
    output logic ref_clk1
);
    int cnt0;
    int cnt1;

    //----------------------------------------
    // two free-running references, whole pclk cycles each, for manual switchover
    //----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt0 <= 0;
            ref_clk0 <= 1'b0;
        end else if (cnt0 == HALF0 - 1) begin
            cnt0 <= 0;
            ref_clk0 <= ~ref_clk0;
        end else begin
            cnt0 <= cnt0 + 1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt1 <= 0;
            ref_clk1 <= 1'b0;
        end else if (cnt1 == HALF1 - 1) begin
            cnt1 <= 0;
            ref_clk1 <= ~ref_clk1;
        end else begin
            cnt1 <= cnt1 + 1;
        end
    end
endmodule // pcs_ref_src

// [sim/pcs_top_monitor.sv]
// assertion checker watching the ports of the pll control
`timescale 1ns/10ps
module pcs_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ref_clk0,
    input wire logic ref_clk1,
    input wire logic pll_enable,
    input wire logic pll_areset,
    input wire logic pfd_enable,
    input wire logic reference_switch_select,
    input wire logic post_scale_out0,
    input wire logic post_scale_out1,
    input wire logic external_capable_output,
    input wire logic ext_clk_pin,
    input wire logic lock_out
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    //----------------------------------------
    // register bus
    //----------------------------------------
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in the cycle after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_unmapped: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
        else $error("unmapped address answered without error");
    a_err_mapped: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
        |=> !pslverr) else $error("mapped address answered with error");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_err_rdata_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data on an error answer");

    //----------------------------------------
    // loop controls
    //----------------------------------------
    a_clear_drops_lock: assert property (pll_areset |-> ##[1:3] !lock_out)
        else $error("lock not dropped after clear");
    a_lock_held_clear: assert property (pll_areset [*4] |-> !lock_out)
        else $error("lock shown during a held clear");
    a_off_drops_lock: assert property (!pll_enable |-> ##[1:3] !lock_out)
        else $error("lock not dropped with the loop off");

    c_bus_error: cover property (pslverr);
    c_lock_rise: cover property ($rose(lock_out));
    c_pin_clock: cover property ($rose(ext_clk_pin));
endmodule // pcs_top_monitor

// [sim/tb.sv]
// self-checking testbench of the pll control
`timescale 1ns/10ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb;
    import pcs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ref_clk0, ref_clk1, pll_enable = 1'b1, pll_areset = 1'b0;
    logic pfd_enable = 1'b1, reference_switch_select = 1'b0;
    logic post_scale_out0, post_scale_out1, external_capable_output, ext_clk_pin, lock_out;
    int mismatches = 0, total_checks = 0;
    localparam logic [7:0] RADR [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    localparam logic [31:0] RDEF [7] = '{32'h60, 32'h0, 32'h10, 32'h400, 32'h400, 32'h400,
                                         32'h102};

    always #12.5 pclk = ~pclk;

    pcs_top i_pcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1), .pll_enable(pll_enable),
        .pll_areset(pll_areset), .pfd_enable(pfd_enable),
        .reference_switch_select(reference_switch_select), .post_scale_out0(post_scale_out0),
        .post_scale_out1(post_scale_out1), .external_capable_output(external_capable_output),
        .ext_clk_pin(ext_clk_pin), .lock_out(lock_out));
    pcs_ref_src #(.HALF0(16), .HALF1(32)) i_pcs_ref_src (.pclk(pclk), .presetn(presetn),
        .ref_clk0(ref_clk0), .ref_clk1(ref_clk1));

    //----------------------------------------
    // checking and verdict
    //----------------------------------------
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    //----------------------------------------
    // bus and clock helpers
    //----------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return post_scale_out0;
            1: return post_scale_out1;
            2: return external_capable_output;
            default: return ext_clk_pin;
        endcase
    endfunction

    // period and high time of one output, in pclk cycles, from one rising edge
    task automatic measure(input int k, input int per, input int hi);
        int n, h;
        n = 0;
        h = 0;
        while (sig(k) !== 1'b0 && n < 2000) begin @(posedge pclk); n++; end
        while (sig(k) !== 1'b1 && n < 2000) begin @(posedge pclk); n++; end
        n = 0;
        while (sig(k) === 1'b1 && n < 2000) begin @(posedge pclk); n++; h++; end
        while (sig(k) !== 1'b1 && n < 2000) begin @(posedge pclk); n++; end
        `CHK(h, hi);
        `CHK(n, per);
    endtask

    // clear the loop, release on a reference rise, count cycles to lock
    task automatic restart(output int t);
        pll_areset <= 1'b1;
        repeat (2) @(posedge pclk);
        while (ref_clk0 !== 1'b0) @(posedge pclk);
        while (ref_clk0 !== 1'b1) @(posedge pclk);
        pll_areset <= 1'b0;
        t = 0;
        while (lock_out !== 1'b1 && t < 3000) begin @(posedge pclk); t++; end
    endtask

    //----------------------------------------
    // tests
    //----------------------------------------
    initial begin
        logic [31:0] rv;
        logic er;
        int t0, t1, n;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(RADR[i], 1'b0, 32'h0, rv, er);
            `CHK(rv, RDEF[i]);
        end
        apb(8'h40, 1'b0, 32'h0, rv, er);
        `CHK({er, rv[7:0]}, 9'h100);
        for (int m = 0; m < 3; m++) begin
            wr(8'h00, 32'h60 | m);
            apb(8'h00, 1'b0, 32'h0, rv, er);
            `CHK(rv, 32'h60 | m);
        end
        wr(8'h00, 32'h60);
        wr(8'h04, 32'h1);
        wr(8'h0C, 32'h0401);
        wr(8'h10, 32'h0803);
        wr(8'h14, 32'h0400);
        restart(t0);
        `CHK(t0 < 3000, 1);
        apb(8'h18, 1'b0, 32'h0, rv, er);
        `CHK({rv[3], rv[0]}, 2'h3);
        measure(0, 32, 8);
        measure(1, 64, 16);
        measure(2, 16, 8);
        measure(3, 16, 8);
        wr(8'h00, 32'h20);
        // let the output flop take the new enable before counting
        @(posedge pclk);
        n = 0;
        repeat (40) begin @(posedge pclk); n += (external_capable_output === 1'b1); end
        `CHK(n, 0);
        measure(3, 16, 8);
        pfd_enable <= 1'b0;
        apb(8'h18, 1'b0, 32'h0, rv, er);
        `CHK(rv[4], 0);
        wr(8'h1C, 32'h10A);
        repeat (70) @(posedge pclk);
        `CHK(lock_out, 0);
        pfd_enable <= 1'b1;
        repeat (100) @(posedge pclk);
        `CHK(lock_out, 1);
        wr(8'h00, 32'h60);
        wr(8'h08, 32'h4);
        restart(t0);
        wr(8'h00, 32'h70);
        restart(t1);
        `CHK((t1 - t0 >= 48) && (t1 - t0 <= 66), 1);
        pll_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(lock_out, 0);
        apb(8'h18, 1'b0, 32'h0, rv, er);
        `CHK(rv[3], 0);
        pll_enable <= 1'b1;
        wr(8'h00, 32'h68);
        reference_switch_select <= 1'b1;
        restart(t0);
        `CHK(t0 < 3000, 1);
        apb(8'h18, 1'b0, 32'h0, rv, er);
        `CHK(rv[2], 1);
        measure(0, 64, 16);
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule // tb

bind pcs_top pcs_top_monitor i_pcs_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1),
    .pll_enable(pll_enable), .pll_areset(pll_areset), .pfd_enable(pfd_enable),
    .reference_switch_select(reference_switch_select), .post_scale_out0(post_scale_out0),
    .post_scale_out1(post_scale_out1), .external_capable_output(external_capable_output),
    .ext_clk_pin(ext_clk_pin), .lock_out(lock_out));
